//--- nhc_pkg.sv
// package: constants and types for the host register interface
package nhc_pkg;
  // ==========================================
  // register map
  localparam logic [31:0] ROM_BASE       = 32'h1012_0000;
  localparam logic [31:0] ROM_LAST       = 32'h1012_007c;
  localparam int          ROM_BYTES      = 32;
  localparam int          ROM_ADDR_W     = 5;
  localparam int          PHYS_BYTES     = 6;
  localparam int          CSR_COUNT      = 16;
  localparam int          CSR_IDX_W      = 4;
  localparam logic [3:0]  CSR_VEC        = 4'h0;
  localparam logic [3:0]  CSR_STATUS     = 4'h5;
  localparam logic [3:0]  CSR_VIRT_FIRST = 4'h8;
  localparam logic [3:0]  CSR_VIRT_LAST  = 4'he;
  // ==========================================
  // vector/priority register layout
  localparam logic [31:0] VEC_RESET      = 32'h1fff_0003;
  localparam logic [31:0] VEC_RW_MASK    = 32'he000_fffc;
  localparam logic [31:0] VEC_ONES       = 32'h1fff_0003;
  localparam int          VEC_SYNC_BIT   = 29;
  localparam int          VEC_LVL_LSB    = 30;
  localparam logic [7:0]  LVL_BASE       = 8'h14;
  // ==========================================
  // status register layout
  localparam int          ST_MERR_BIT    = 4;
  localparam int          ST_DONE_BIT    = 16;
  // fixed ones leave the done bit free, or done would always read set
  localparam logic [31:0] ST_ONES        = 32'h0002_ff00;
  // ==========================================
  // timing
  localparam int          CLK_MHZ        = 50;
  localparam int          VIRT_MAX_US    = 20;
  localparam int          VIRT_MAX_CYC   = VIRT_MAX_US * CLK_MHZ;
  // ==========================================
  // process states
  typedef enum logic [1:0] {
    NHC_STOPPED   = 2'b00,
    NHC_RUNNING   = 2'b01,
    NHC_SUSPENDED = 2'b11
  } nhc_proc_t;
endpackage

//--- nhc_rom.sv
// station address rom: 32 bytes, first six hold the physical address
`timescale 1ns/10ps
`default_nettype none
module nhc_rom #(
  parameter logic [47:0] PHYS_ADDR = 48'h5e_4d_3c_2b_1a_02  // arbitrary value
) (
  input  wire logic                         clk,
  input  wire logic [nhc_pkg::ROM_ADDR_W-1:0] addr,
  output logic      [7:0]                   data
);
  import nhc_pkg::*;
  logic [7:0] data_next;
  always_comb begin
    data_next = 8'h00;  // RULE_02
    if (int'(addr) < PHYS_BYTES) begin
      data_next = PHYS_ADDR[8*int'(addr) +: 8];  // RULE_02
    end
  end
  always_ff @(posedge clk) begin
    data <= data_next;
  end
endmodule
`default_nettype wire

//--- nhc_csr.sv
// host register interface of the network controller
// Summary of operation
// RULE_01 - 32 rom bytes in low byte of longwords
// RULE_02 - first six bytes give physical address
// RULE_03 - writes to rom range are ignored
// RULE_04 - sixteen longword registers at base plus 4x
// RULE_05 - reserved bits read fixed, ignore writes
// RULE_06 - read only bits ignore writes
// RULE_07 - write one clears flag bits
// RULE_08 - physical registers answer immediately
// RULE_09 - virtual registers served by internal processor
// RULE_10 - done flag clears, sets when action ends
// RULE_11 - host polls done before next virtual access
// RULE_12 - virtual write completes, data taken later
// RULE_13 - first virtual read invalid, reread valid
// RULE_14 - host writes vector register first
// RULE_15 - host writes vector register at disabled level
// RULE_16 - host verifies vector write, clears memory error
// RULE_17 - acknowledge drives vector, upper lines zero
// RULE_18 - vector low two bits read ones
// RULE_19 - bit 29 selects synchronous bus master mode
// RULE_20 - bits 31:30 select interrupt level 14..17
// RULE_21 - vector register resets to 1fff0003
// RULE_22 - receive and transmit processes have three states
// RULE_23 - done flag set after reset
// RULE_24 - write parity error sets memory error flag
// RULE_25 - virtual access number and data held
`timescale 1ns/10ps
`default_nettype none
module nhc_csr #(
  parameter logic [31:0] CSR_BASE = 32'h1000_0000
) (
  input  wire logic                          clk,
  input  wire logic                          reset,
  // host access
  input  wire logic                          host_valid,
  input  wire logic                          host_write,
  input  wire logic [31:0]                   host_addr,
  input  wire logic [31:0]                   host_wdata,
  input  wire logic                          host_parity_err,
  output logic                               host_ready,
  output logic      [31:0]                   host_rdata,
  // interrupt acknowledge
  input  wire logic                          intack,
  output logic      [31:0]                   intack_data,
  // mode outputs
  output logic                               sync_async_select,
  output logic      [7:0]                    interrupt_priority_level,
  output logic                               irq,
  // internal processor side
  output logic                               virt_req,
  output logic                               virt_write,
  output logic      [nhc_pkg::CSR_IDX_W-1:0] virt_idx,
  output logic      [31:0]                   virt_wdata,
  input  wire logic                          virt_done,
  input  wire logic [31:0]                   virt_rdata,
  // process events from the engines
  input  wire logic                          rx_start,
  input  wire logic                          rx_suspend,
  input  wire logic                          rx_stop,
  input  wire logic                          tx_start,
  input  wire logic                          tx_suspend,
  input  wire logic                          tx_stop,
  output nhc_pkg::nhc_proc_t                 rx_state,
  output nhc_pkg::nhc_proc_t                 tx_state
);
  import nhc_pkg::*;

  // ==========================================
  // decode
  function automatic logic is_virtual(input logic [CSR_IDX_W-1:0] idx);
    is_virtual = (idx >= CSR_VIRT_FIRST) && (idx <= CSR_VIRT_LAST);  // RULE_09
  endfunction

  logic                 in_rom;
  logic                 in_csr;
  logic [CSR_IDX_W-1:0] idx;
  logic [31:0]          csr_off;
  logic [7:0]           rom_byte;
  logic                 acc;
  logic                 wr;

  assign csr_off = host_addr - CSR_BASE;
  assign in_rom  = (host_addr >= ROM_BASE) && (host_addr <= ROM_LAST) && (host_addr[1:0] == 2'b00);  // RULE_01
  assign in_csr  = (csr_off < 32'(4 * CSR_COUNT)) && (host_addr[1:0] == 2'b00);  // RULE_04
  assign idx     = csr_off[CSR_IDX_W+1:2];  // RULE_04
  assign acc     = host_valid && in_csr;
  assign wr      = acc && host_write;
  assign host_ready = host_valid;  // RULE_08 RULE_12 RULE_13

  nhc_rom u_rom (
    .clk  (clk),
    .addr (host_addr[ROM_ADDR_W+1:2]),
    .data (rom_byte)
  );

  // ==========================================
  // vector, priority and mode register
  logic [31:0] vec_reg;
  logic [31:0] vec_next;

  // a vector write with bad parity is dropped whole, so a corrupt vector never reaches the acknowledge lines
  always_comb begin
    vec_next = vec_reg;
    if (wr && idx == CSR_VEC && !host_parity_err) begin
      vec_next = (host_wdata & VEC_RW_MASK) | (VEC_ONES & ~VEC_RW_MASK);  // RULE_05 RULE_18
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      vec_reg <= VEC_RESET;  // RULE_21
    end else begin
      vec_reg <= vec_next;
    end
  end

  // ==========================================
  // memory error flag
  logic merr_reg;
  logic merr_next;

  always_comb begin
    merr_next = merr_reg;
    // done is read only; a status write reaches the error flag alone
    if (wr && idx == CSR_STATUS && host_wdata[ST_MERR_BIT]) begin  // RULE_06
      merr_next = 1'b0;  // RULE_07
    end
    // set after clear: a parity error in the clearing write itself still counts
    if (wr && host_parity_err) begin
      merr_next = 1'b1;  // RULE_24
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      merr_reg <= 1'b0;
    end else begin
      merr_reg <= merr_next;
    end
  end

  // ==========================================
  // virtual register hand-off
  logic                 done_reg;
  logic                 done_next;
  logic                 vreq_reg;
  logic                 vreq_next;
  logic                 vwr_reg;
  logic                 vwr_next;
  logic [CSR_IDX_W-1:0] vidx_reg;
  logic [CSR_IDX_W-1:0] vidx_next;
  logic [31:0]          vdat_reg;
  logic [31:0]          vdat_next;
  logic [31:0]          vres_reg;
  logic [31:0]          vres_next;
  logic                 virt_start;
  logic                 virt_finish;

  // a virtual access while busy is dropped; the host must poll first
  assign virt_start  = acc && is_virtual(idx) && done_reg;  // RULE_10
  assign virt_finish = vreq_reg && virt_done;

  always_comb begin
    done_next = done_reg;
    vreq_next = vreq_reg;
    vwr_next  = vwr_reg;
    vidx_next = vidx_reg;
    vdat_next = vdat_reg;
    vres_next = vres_reg;
    if (virt_start) begin
      done_next = 1'b0;  // RULE_10
      vreq_next = 1'b1;
      vwr_next  = host_write;  // RULE_25
      vidx_next = idx;  // RULE_25
      vdat_next = host_wdata;  // RULE_25
    end else if (virt_finish) begin
      done_next = 1'b1;  // RULE_10
      vreq_next = 1'b0;
      // the result waits here for the host's repeated read
      if (!vwr_reg) begin
        vres_next = virt_rdata;  // RULE_13
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      done_reg <= 1'b1;  // RULE_23
      vreq_reg <= 1'b0;
      vwr_reg  <= 1'b0;
      vidx_reg <= '0;
      vdat_reg <= 32'h0000_0000;
      vres_reg <= 32'h0000_0000;
    end else begin
      done_reg <= done_next;
      vreq_reg <= vreq_next;
      vwr_reg  <= vwr_next;
      vidx_reg <= vidx_next;
      vdat_reg <= vdat_next;
      vres_reg <= vres_next;
    end
  end

  // ==========================================
  // receive and transmit process states
  function automatic nhc_proc_t proc_step(input nhc_proc_t cur,
                                         input logic      go,
                                         input logic      sus,
                                         input logic      stp);
    proc_step = cur;
    unique case (cur)
      NHC_STOPPED: begin
        if (go) begin
          proc_step = NHC_RUNNING;
        end
      end
      NHC_RUNNING: begin
        if (stp) begin
          proc_step = NHC_STOPPED;
        end else if (sus) begin
          proc_step = NHC_SUSPENDED;
        end
      end
      NHC_SUSPENDED: begin
        if (stp) begin
          proc_step = NHC_STOPPED;
        end else if (go) begin
          proc_step = NHC_RUNNING;
        end
      end
      default: begin
        proc_step = NHC_STOPPED;
      end
    endcase
  endfunction

  nhc_proc_t rx_reg;
  nhc_proc_t rx_next;
  nhc_proc_t tx_reg;
  nhc_proc_t tx_next;

  // a pending memory error aborts both processes into stopped
  always_comb begin
    rx_next = proc_step(rx_reg, rx_start, rx_suspend, rx_stop || merr_reg);  // RULE_22
    tx_next = proc_step(tx_reg, tx_start, tx_suspend, tx_stop || merr_reg);  // RULE_22
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_reg <= NHC_STOPPED;
      tx_reg <= NHC_STOPPED;
    end else begin
      rx_reg <= rx_next;
      tx_reg <= tx_next;
    end
  end

  // ==========================================
  // read data
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        rd_rom_reg;
  logic        rd_rom_next;

  always_comb begin
    rdata_next  = 32'h0000_0000;
    // writes to the rom range fall through with no effect
    rd_rom_next = host_valid && !host_write && in_rom;  // RULE_03
    if (acc && !host_write) begin
      unique case (idx)
        CSR_VEC: begin
          rdata_next = vec_reg;
        end
        CSR_STATUS: begin
          rdata_next = ST_ONES | (32'(done_reg) << ST_DONE_BIT) | (32'(merr_reg) << ST_MERR_BIT);  // RULE_05
        end
        default: begin
          rdata_next = is_virtual(idx) ? vres_reg : 32'h0000_0000;  // RULE_13
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_reg  <= 32'h0000_0000;
      rd_rom_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rd_rom_reg <= rd_rom_next;
    end
  end

  // ==========================================
  // outputs
  // the rom byte arrives one clock after the request, like register data; its upper bytes read zero
  assign host_rdata               = rd_rom_reg ? {24'h00_0000, rom_byte} : rdata_reg;  // RULE_01 RULE_02
  assign intack_data              = intack ? {16'h0000, vec_reg[15:0]} : 32'h0000_0000;  // RULE_17
  assign sync_async_select        = vec_reg[VEC_SYNC_BIT];  // RULE_19
  assign interrupt_priority_level = LVL_BASE + {6'h00, vec_reg[VEC_LVL_LSB +: 2]};  // RULE_20
  assign irq                      = merr_reg;  // RULE_24
  assign virt_req                 = vreq_reg;  // RULE_09
  assign virt_write               = vwr_reg;
  assign virt_idx                 = vidx_reg;
  assign virt_wdata               = vdat_reg;
  assign rx_state                 = rx_reg;
  assign tx_state                 = tx_reg;
endmodule
`default_nettype wire

//--- nhc_csr_properties.sv
// checker: port relations of the host register interface
`timescale 1ns/10ps
`default_nettype none
module nhc_csr_properties #(
  parameter logic [31:0] CSR_BASE = 32'h1000_0000
) (
  input wire logic                          clk,
  input wire logic                          reset,
  input wire logic                          host_valid,
  input wire logic                          host_write,
  input wire logic [31:0]                   host_addr,
  input wire logic [31:0]                   host_wdata,
  input wire logic                          host_parity_err,
  input wire logic                          host_ready,
  input wire logic                          intack,
  input wire logic [31:0]                   intack_data,
  input wire logic [7:0]                    interrupt_priority_level,
  input wire logic                          irq,
  input wire logic                          virt_req,
  input wire logic [nhc_pkg::CSR_IDX_W-1:0] virt_idx,
  input wire logic [31:0]                   virt_wdata,
  input wire logic                          virt_done
);
  import nhc_pkg::*;
  // ==========================================
  // decoded requests
  logic vec_wr;
  logic virt_acc;
  assign vec_wr = host_valid && host_write && !host_parity_err && host_addr == CSR_BASE;
  assign virt_acc = host_valid && host_addr[31:6] == CSR_BASE[31:6] && host_addr[1:0] == 2'b00
    && host_addr[5:2] >= CSR_VIRT_FIRST && host_addr[5:2] <= CSR_VIRT_LAST;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================================
  // assertions
  chk_ready_now: assert property (host_valid |-> host_ready)
    else $error("ready missing during request");
  chk_vec_lines: assert property (vec_wr |=> intack_data == (intack ?
    {16'h0, $past(host_wdata[15:2]), 2'b11} : 32'h0)) else $error("acknowledge lines wrong");
  chk_ipl_map: assert property (vec_wr |=> interrupt_priority_level ==
    8'h14 + 8'($past(host_wdata[31:30]))) else $error("priority level wrong");
  chk_parity_flag: assert property (host_valid && host_write && host_parity_err |=> irq)
    else $error("parity error not flagged");
  chk_virt_start: assert property (virt_acc && !virt_req |=>
    virt_req && virt_idx == $past(host_addr[5:2])) else $error("virtual access not launched");
  chk_virt_hold: assert property (virt_req && !virt_done |=>
    virt_req && $stable(virt_idx) && $stable(virt_wdata)) else $error("virtual request not held");
  chk_virt_end: assert property (virt_req && virt_done |=> !virt_req)
    else $error("virtual request not ended");
  chk_reset_vec: assert property ($fell(reset) |-> intack_data == (intack ? 32'h0000_0003 : 32'h0)
    && interrupt_priority_level == 8'h14 && !virt_req) else $error("reset values wrong");
endmodule
bind nhc_csr nhc_csr_properties #(.CSR_BASE(CSR_BASE)) i_chk (.clk, .reset, .host_valid,
  .host_write, .host_addr, .host_wdata, .host_parity_err, .host_ready, .intack, .intack_data,
  .interrupt_priority_level, .irq, .virt_req, .virt_idx, .virt_wdata, .virt_done);
`default_nettype wire

//--- nhc_ip_model.sv
// internal processor model serving the virtual registers
`timescale 1ns/10ps
`default_nettype none
module nhc_ip_model #(
  parameter int DELAY = 7
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        virt_req,
  input wire logic        virt_write,
  input wire logic [3:0]  virt_idx,
  input wire logic [31:0] virt_wdata,
  output logic            virt_done,
  output logic     [31:0] virt_rdata
);
  // ==========================================
  // slow service with a register store
  logic [31:0] store [16];
  int cnt;
  always_ff @(posedge clk) begin
    if (reset || !virt_req || virt_done) cnt <= 0;
    else cnt <= cnt + 1;
    virt_done <= !reset && virt_req && !virt_done && cnt == DELAY;
    if (virt_req && virt_write && cnt == DELAY) store[virt_idx] <= virt_wdata;
  end
  // data only holds meaning with the done pulse; otherwise show a changed pattern
  assign virt_rdata = virt_done ? store[virt_idx] : ~store[virt_idx];
endmodule
`default_nettype wire

//--- nic_host_csr_interface_test.sv
// testbench: host register access sequences with expected values
`timescale 1ns/10ps
`default_nettype none
module nic_host_csr_interface_test;
  import nhc_pkg::*;
  localparam logic [31:0] B = 32'h1000_0000;
  localparam logic [47:0] PHYS = 48'h5e_4d_3c_2b_1a_02;  // rom default address, arbitrary
  logic clk = 0, reset = 1, host_valid = 0, host_write = 0, host_parity_err = 0, intack = 0;
  logic [31:0] host_addr = 0, host_wdata = 0, host_rdata, intack_data, virt_wdata, virt_rdata, rd, d;
  logic host_ready, sync_async_select, irq, virt_req, virt_write, virt_done;
  logic [7:0] interrupt_priority_level;
  logic [3:0] virt_idx;
  logic [5:0] ev = 0;
  nhc_proc_t rx_state, tx_state;
  int fails = 0, total_checks = 0;
  nhc_csr #(.CSR_BASE(B)) i_dut (.clk, .reset, .host_valid, .host_write, .host_addr, .host_wdata,
    .host_parity_err, .host_ready, .host_rdata, .intack, .intack_data, .sync_async_select,
    .interrupt_priority_level, .irq, .virt_req, .virt_write, .virt_idx, .virt_wdata, .virt_done,
    .virt_rdata, .rx_start(ev[5]), .rx_suspend(ev[4]), .rx_stop(ev[3]), .tx_start(ev[2]),
    .tx_suspend(ev[1]), .tx_stop(ev[0]), .rx_state, .tx_state);
  nhc_ip_model #(.DELAY(7)) i_ip (.clk, .reset, .virt_req, .virt_write, .virt_idx, .virt_wdata,
    .virt_done, .virt_rdata);
  initial forever #10 clk = ~clk;
  // ==========================================
  // tasks
  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [31:0] a, dat = 0, input logic p = 0);
    @(posedge clk);
    #1 {host_valid, host_write, host_addr, host_wdata, host_parity_err} = {1'b1, w, a, dat, p};
    @(posedge clk);
    #1 {host_valid, host_parity_err} = 2'b00;
    rd = host_rdata;
  endtask
  task automatic wait_done;
    for (int i = 0; i < VIRT_MAX_CYC / 2; i++) begin
      acc(0, B + 32'h14);
      if (rd[ST_DONE_BIT] === 1'b1) return;
    end
    chk("done wait", 1, 0);
  endtask
  task automatic evt(input logic [5:0] v, input nhc_proc_t s);
    @(posedge clk);
    #1 ev = v;
    @(posedge clk);
    #1 ev = 0;
    chk("rx state", 32'(s), 32'(rx_state));
    chk("tx state", 32'(s), 32'(tx_state));
  endtask
  task automatic final_report;
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================
  // sequence
  initial begin
    repeat (16) @(posedge clk);
    #1 reset = 0;
    acc(0, B);
    chk("vector reset", VEC_RESET, rd);
    acc(0, B + 32'h14);
    chk("status reset", ST_ONES | 32'h0001_0000, rd & 32'h0003_ff10);
    evt(6'b100100, NHC_RUNNING);
    evt(6'b010010, NHC_SUSPENDED);
    evt(6'b001001, NHC_STOPPED);
    evt(6'b100100, NHC_RUNNING);
    intack = 1;
    for (int i = 0; i < 4; i++) begin
      d = {i[1:0], i[0], 25'h0, i[3:0]} ^ 32'h0000_a5a0;
      acc(1, B, d);
      acc(0, B);
      chk("vector readback", (d & VEC_RW_MASK) | VEC_ONES, rd);
      chk("level", 32'h14 + i, 32'(interrupt_priority_level));
      chk("mode", 32'(i[0]), 32'(sync_async_select));
      chk("ack lines", {16'h0, d[15:2], 2'b11}, intack_data);
    end
    intack = 0;
    acc(0, B);
    chk("ack idle", 0, intack_data);
    acc(1, ROM_BASE, 32'hffff_ffff);
    for (int k = 0; k < ROM_BYTES; k++) begin
      acc(0, ROM_BASE + 32'(4 * k));
      chk("rom byte", k < PHYS_BYTES ? 32'(PHYS[8*k +: 8]) : 32'h0, rd & 32'h0000_00ff);
    end
    acc(1, B + 32'h1, 32'h0);
    acc(1, B, 32'h0, 1);
    acc(0, B);
    chk("vector kept", (d & VEC_RW_MASK) | VEC_ONES, rd);
    chk("error irq", 1, irq);
    chk("rx stopped", 32'(NHC_STOPPED), 32'(rx_state));
    acc(1, B + 32'h14, 32'hffff_ffef);
    acc(0, B + 32'h14);
    chk("status kept", ST_ONES | 32'h0001_0010, rd & 32'h0003_ff10);
    acc(1, B + 32'h14, 32'h10);
    acc(0, B + 32'h14);
    chk("error cleared", 0, rd[ST_MERR_BIT]);
    acc(1, B + 32'h3c, 32'h0);
    acc(0, B + 32'h14);
    chk("physical done", 1, rd[ST_DONE_BIT]);
    for (int k = 8; k < 15; k += 6) begin
      acc(1, B + 32'(4 * k), 32'h3c5a_9600 + k);
      acc(0, B + 32'h14);
      chk("done cleared", 0, rd[ST_DONE_BIT]);
      wait_done();
      acc(0, B + 32'(4 * k));
      wait_done();
      acc(0, B + 32'(4 * k));
      chk("virtual read", 32'h3c5a_9600 + k, rd);
      wait_done();
    end
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk);
    chk("watchdog", 0, 1);
    final_report();
  end
endmodule
`default_nettype wire
